// >>> core/qsim_top.v
// quad sinking input module: input image, object access and indicators
`timescale 1ns/1ps
`include "qsim_regs.vh"
module qsim_top
(
	input wire mclk,
	input wire sys_rst,
	input wire [3:0] channel_input_n,
	input wire bus_comm_ok,
	input wire module_error,
	input wire bus_power_ok,
	input wire config_error,
	input wire [7:0] slot_num,
	input wire rd_en,
	input wire [7:0] rd_addr,
	output reg [7:0] rd_data,
	input wire obj_rd_en,
	input wire [15:0] obj_index,
	input wire [7:0] obj_subindex,
	output reg [7:0] obj_data,
	output reg obj_valid,
	output reg obj_error,
	input wire wr_en,
	input wire [7:0] wr_addr,
	input wire [7:0] wr_data,
	output reg run_led,
	output reg module_fault_led,
	output wire [3:0] channel_led
);
// ----------------------------------------
// input capture
// ----------------------------------------

wire [3:0] chan_state;
wire blink;
reg [7:0] input_state_byte_r;

// field inputs, inverted and synchronised
qsim_sync u_sync
(
	.mclk(mclk),
	.sys_rst(sys_rst),
	.channel_input_n(channel_input_n),
	.chan_state(chan_state)
);

// free-running fault blink phase
qsim_blink u_blink
(
	.mclk(mclk),
	.sys_rst(sys_rst),
	.blink(blink)
);

// channels into their bit positions, reserved bits held at zero
function [7:0] image_of;
	input [3:0] ch;
	begin
		image_of = {`QSIM_RSVD_VAL, 4'h0};
		image_of[`QSIM_CH0_BIT] = ch[0];
		image_of[`QSIM_CH1_BIT] = ch[1];
		image_of[`QSIM_CH2_BIT] = ch[2];
		image_of[`QSIM_CH3_BIT] = ch[3];
	end
endfunction

// input image, refreshed every clock
always @(posedge mclk)
begin
	if (sys_rst)
		input_state_byte_r <= `QSIM_INPUT_BYTE_RST;
	else
		input_state_byte_r <= image_of(chan_state);
end
// ----------------------------------------
// byte read and object access
// ----------------------------------------

// channel number of a subindex, top bit set when it names a channel
function [2:0] sub_to_ch;
	input [7:0] sub;
	begin
		case (sub)
			`QSIM_SUB_CH0: sub_to_ch = {1'h1, 2'h0};
			`QSIM_SUB_CH1: sub_to_ch = {1'h1, 2'h1};
			`QSIM_SUB_CH2: sub_to_ch = {1'h1, 2'h2};
			`QSIM_SUB_CH3: sub_to_ch = {1'h1, 2'h3};
			default: sub_to_ch = {1'h0, 2'h0};
		endcase
	end
endfunction

// channel object: index must match the slot, subindex must name a channel
function obj_is_chan;
	input [15:0] idx;
	input [7:0] slot;
	input hit;
	begin
		obj_is_chan = (idx == (`QSIM_CH_INDEX_BASE + {8'h00, slot})) && hit;
	end
endfunction

// whole-byte object
function obj_is_byte;
	input [15:0] idx;
	begin
		obj_is_byte = (idx == `QSIM_OBJ_INDEX);
	end
endfunction

// one channel of the image, picked by its zero-based number
function chan_pick;
	input [7:0] img;
	input [1:0] ch;
	begin
		case (ch)
			2'h0: chan_pick = img[`QSIM_CH0_BIT];
			2'h1: chan_pick = img[`QSIM_CH1_BIT];
			2'h2: chan_pick = img[`QSIM_CH2_BIT];
			2'h3: chan_pick = img[`QSIM_CH3_BIT];
			default: chan_pick = 1'h0;
		endcase
	end
endfunction

// byte offset decode; anything but the input byte reads as zero
function [7:0] byte_at;
	input [7:0] addr;
	input [7:0] img;
	begin
		if (addr == `QSIM_INPUT_BYTE_OFS)
			byte_at = img;
		else
			byte_at = `QSIM_UNMAPPED_VAL;
	end
endfunction

// decoded subindex of the current object request
wire [2:0] sub_ch = sub_to_ch(obj_subindex);

// ----------------------------------------
// read answers
// ----------------------------------------

reg [7:0] obj_data_nxt;
reg obj_error_nxt;
always @*
begin
	obj_data_nxt = obj_data;
	obj_error_nxt = 1'h0;
	if (obj_rd_en)
	begin
		if (obj_is_byte(obj_index))
		begin
			obj_data_nxt = input_state_byte_r;
		end
		else if (obj_is_chan(obj_index, slot_num, sub_ch[2]))
		begin
			obj_data_nxt = {7'h00, chan_pick(input_state_byte_r, sub_ch[1:0])};
		end
		else
		begin
			obj_data_nxt = `QSIM_UNMAPPED_VAL;
			obj_error_nxt = 1'h1;
		end
	end
end

// strobes answered one clock later
always @(posedge mclk)
begin
	if (sys_rst)
	begin
		rd_data <= `QSIM_INPUT_BYTE_RST;
		obj_data <= `QSIM_INPUT_BYTE_RST;
		obj_valid <= 1'h0;
		obj_error <= 1'h0;
	end
	else
	begin
		if (rd_en)
		begin
			rd_data <= byte_at(rd_addr, input_state_byte_r);
		end
		obj_valid <= obj_rd_en;
		obj_data <= obj_data_nxt;
		obj_error <= obj_error_nxt;
	end
end

// no output area: wr_en, wr_addr and wr_data stay unread.

// ----------------------------------------
// indicators
// ----------------------------------------

// bus and module condition, one-hot
localparam [3:0] COND_PWR_FAIL = 4'h1;
localparam [3:0] COND_RUN_OK = 4'h2;
localparam [3:0] COND_RUN_ERR = 4'h4;
localparam [3:0] COND_BUS_LOST = 4'h8;

// power loss outranks the bus state
function [3:0] cond_of;
	input pwr_ok;
	input comm_ok;
	input err;
	begin
		if (!pwr_ok)
			cond_of = COND_PWR_FAIL;
		else if (comm_ok && !err)
			cond_of = COND_RUN_OK;
		else if (comm_ok)
			cond_of = COND_RUN_ERR;
		else
			cond_of = COND_BUS_LOST;
	end
endfunction

// led levels for each condition
reg [3:0] cond_nxt;
reg run_nxt;
reg fault_nxt;
always @*
begin
	cond_nxt = cond_of(bus_power_ok, bus_comm_ok, module_error);
	run_nxt = 1'h0;
	fault_nxt = 1'h0;
	case (cond_nxt)
		COND_PWR_FAIL:
		begin
			run_nxt = 1'h0;
			fault_nxt = 1'h0;
		end
		COND_RUN_OK:
		begin
			run_nxt = 1'h1;
			fault_nxt = 1'h0;
		end
		COND_RUN_ERR:
		begin
			run_nxt = 1'h1;
			fault_nxt = 1'h1;
		end
		COND_BUS_LOST:
		begin
			run_nxt = 1'h0;
			fault_nxt = 1'h1;
		end
		default:
		begin
			run_nxt = 1'h0;
			fault_nxt = 1'h0;
		end
	endcase
	// configuration error overrides the fault led only
	if (config_error)
	begin
		fault_nxt = blink;
	end
end

// registered so the leds never glitch
always @(posedge mclk)
begin
	if (sys_rst)
	begin
		run_led <= 1'h0;
		module_fault_led <= 1'h0;
	end
	else
	begin
		run_led <= run_nxt;
		module_fault_led <= fault_nxt;
	end
end

// ----------------------------------------
// channel indicators
// ----------------------------------------

// taken from the image alone, so they work without bus power
assign channel_led[0] = input_state_byte_r[`QSIM_CH0_BIT];
assign channel_led[1] = input_state_byte_r[`QSIM_CH1_BIT];
assign channel_led[2] = input_state_byte_r[`QSIM_CH2_BIT];
assign channel_led[3] = input_state_byte_r[`QSIM_CH3_BIT];

endmodule // qsim_top

// >>> core/qsim_regs.vh
// register map, object indexes and timing constants of the quad sinking input module
`ifndef QSIM_REGS_VH
`define QSIM_REGS_VH
`define QSIM_NUM_CH 4
`define QSIM_INPUT_BYTE_OFS 8'h00
`define QSIM_CH_LSB 0
`define QSIM_CH_MSB 3
`define QSIM_RSVD_VAL 4'h0
`define QSIM_INPUT_BYTE_RST 8'h00
`define QSIM_OBJ_INDEX 16'h5000
`define QSIM_CH_INDEX_BASE 16'h6000
`define QSIM_CH_SUB_FIRST 8'h01
`define QSIM_SUB_CH0 8'h01
`define QSIM_SUB_CH1 8'h02
`define QSIM_SUB_CH2 8'h03
`define QSIM_SUB_CH3 8'h04
`define QSIM_CH0_BIT 0
`define QSIM_CH1_BIT 1
`define QSIM_CH2_BIT 2
`define QSIM_CH3_BIT 3
`define QSIM_UNMAPPED_VAL 8'h00
`define QSIM_CLK_HZ 20000000
`define QSIM_BLINK_HZ 2
`define QSIM_BLINK_HALF_CYC (`QSIM_CLK_HZ / (2 * `QSIM_BLINK_HZ))
`define QSIM_BLINK_CNT_W 23
`endif

// >>> core/qsim_sync.v
// two-stage synchroniser with sinking-input inversion per channel
`timescale 1ns/1ps
module qsim_sync
(
	input wire mclk,
	input wire sys_rst,
	input wire [3:0] channel_input_n,
	output wire [3:0] chan_state
);
reg [3:0] meta_r;
reg [3:0] sync_r;
always @(posedge mclk)
begin
	if (sys_rst)
	begin
		meta_r <= 4'h0;
		sync_r <= 4'h0;
	end
	else
	begin
		meta_r <= ~channel_input_n;
		sync_r <= meta_r;
	end
end
assign chan_state = sync_r;
endmodule // qsim_sync

// >>> core/qsim_blink.v
// 2 hz blink generator for the fault indicator
`timescale 1ns/1ps
`include "qsim_regs.vh"
module qsim_blink
(
	input wire mclk,
	input wire sys_rst,
	output wire blink
);
localparam integer HALF_CYC = `QSIM_BLINK_HALF_CYC - 1;
localparam [`QSIM_BLINK_CNT_W-1:0] HALF = HALF_CYC[`QSIM_BLINK_CNT_W-1:0];
reg [`QSIM_BLINK_CNT_W-1:0] cnt_r;
reg ph_r;
always @(posedge mclk)
begin
	if (sys_rst)
	begin
		cnt_r <= {`QSIM_BLINK_CNT_W{1'b0}};
		ph_r <= 1'b0;
	end
	else if (cnt_r == HALF)
	begin
		cnt_r <= {`QSIM_BLINK_CNT_W{1'b0}};
		ph_r <= ~ph_r;
	end
	else
	begin
		cnt_r <= cnt_r + {{(`QSIM_BLINK_CNT_W-1){1'b0}}, 1'b1};
	end
end
assign blink = ph_r;
endmodule // qsim_blink

// >>> tb/qsim_monitor.sv
// port assertions of the input module
`timescale 1ns/1ps
module qsim_monitor
(
	input wire mclk, sys_rst, bus_comm_ok, module_error, bus_power_ok, config_error,
	input wire rd_en, obj_rd_en, obj_valid, run_led, module_fault_led,
	input wire [3:0] channel_input_n, channel_led,
	input wire [7:0] rd_addr, rd_data
);
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	wire up = bus_power_ok && !config_error;
	sequence rd0; rd_en && rd_addr == 8'h00; endsequence
	rsvd_zero_a: assert property (rd_data[7:4] == 4'h0) else $error("rsvd");
	byte_image_a: assert property (rd0 |=> rd_data[3:0] == $past(channel_led)) else $error("byte");
	unmapped_a: assert property (rd_en && rd_addr != 8'h00 |=> rd_data == 8'h00) else $error("unmap");
	led_follow_a: assert property (channel_led == ~$past(channel_input_n, 3)) else $error("led");
	obj_answer_a: assert property (obj_rd_en |=> obj_valid) else $error("obj");
	comm_ok_a: assert property (up && bus_comm_ok |=> run_led && module_fault_led == $past(module_error))
		else $error("ok");
	comm_lost_a: assert property (up && !bus_comm_ok |=> !run_led && module_fault_led) else $error("lost");
	power_off_a: assert property (!bus_power_ok && !config_error |=> !run_led && !module_fault_led)
		else $error("pwr");
	cfg_run_a: assert property (config_error && bus_power_ok && bus_comm_ok |=> run_led) else $error("cfg");
endmodule // qsim_monitor
bind qsim_top qsim_monitor qsim_monitor_inst (.mclk(mclk), .sys_rst(sys_rst), .bus_comm_ok(bus_comm_ok),
	.module_error(module_error), .bus_power_ok(bus_power_ok), .config_error(config_error), .rd_en(rd_en),
	.obj_rd_en(obj_rd_en), .obj_valid(obj_valid), .run_led(run_led), .module_fault_led(module_fault_led),
	.channel_input_n(channel_input_n), .channel_led(channel_led), .rd_addr(rd_addr), .rd_data(rd_data));

// >>> tb/qsim_host.sv
// host model issuing byte and object reads
`timescale 1ns/1ps
module qsim_host
(
	input wire mclk,
	output reg rd_en = 1'h0, obj_rd_en = 1'h0,
	output reg [7:0] rd_addr = 8'h00, obj_subindex = 8'h00,
	output reg [15:0] obj_index = 16'h0000
);
	task ask(input [7:0] a, input [15:0] x, input [7:0] s);
		@(posedge mclk) {rd_en, obj_rd_en, rd_addr, obj_index, obj_subindex} <= {2'h3, a, x, s};
		@(posedge mclk) {rd_en, obj_rd_en} <= 2'h0;
		#1;
	endtask
endmodule // qsim_host

// >>> tb/quad_sinking_input_module_test.sv
// self-checking bench of the input module
`timescale 1ns/1ps
module quad_sinking_input_module_test;
	reg mclk = 1'h0, sys_rst = 1'h1, bus_comm_ok = 1'h1, module_error = 1'h0, bus_power_ok = 1'h1;
	reg config_error = 1'h0, wr_en = 1'h0;
	reg [3:0] channel_input_n = 4'hf;
	reg [7:0] wr_data = 8'h00;
	wire [7:0] slot_num = 8'h03, wr_addr = 8'h00, rd_addr, rd_data, obj_subindex, obj_data;
	wire rd_en, obj_rd_en, obj_valid, obj_error, run_led, module_fault_led;
	wire [15:0] obj_index;
	wire [3:0] channel_led;
	reg [19:0] tbl = 20'hd7ea4;
	integer n_mismatch = 0, checks_done = 0, i;
	always #25 mclk = ~mclk;
	qsim_top qsim_top_inst (.mclk(mclk), .sys_rst(sys_rst), .channel_input_n(channel_input_n),
		.bus_comm_ok(bus_comm_ok), .module_error(module_error), .bus_power_ok(bus_power_ok),
		.config_error(config_error), .slot_num(slot_num), .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data),
		.obj_rd_en(obj_rd_en), .obj_index(obj_index), .obj_subindex(obj_subindex), .obj_data(obj_data),
		.obj_valid(obj_valid), .obj_error(obj_error), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
		.run_led(run_led), .module_fault_led(module_fault_led), .channel_led(channel_led));
	qsim_host qsim_host_inst (.mclk(mclk), .rd_en(rd_en), .obj_rd_en(obj_rd_en), .rd_addr(rd_addr),
		.obj_subindex(obj_subindex), .obj_index(obj_index));
	task chk(input [63:0] what, input [9:0] seen, input [9:0] exp);
		checks_done = checks_done + 1;
		if (seen !== exp)
		begin
			n_mismatch = n_mismatch + 1;
			$display("BAD %0s exp %h seen %h", what, exp, seen);
		end
	endtask
	task results;
		$display("%0d checks %0d bad", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial
	begin
		repeat (6) @(posedge mclk);
		sys_rst <= 1'h0;
		for (i = 0; i < 4; i = i + 1)
		begin
			@(posedge mclk) channel_input_n <= ~(4'h1 << i);
			repeat (3) @(posedge mclk);
			qsim_host_inst.ask(8'h00, 16'h6003, 8'h01 + i[7:0]);
			chk("rd_data", rd_data, 4'h1 << i);
			chk("chan_led", channel_led, 4'h1 << i);
			chk("obj_chan", {obj_valid, obj_error, obj_data}, 10'h201);
		end
		qsim_host_inst.ask(8'h01, 16'h5000, 8'h00);
		chk("rd_unmap", rd_data, 8'h00);
		chk("obj_byte", {obj_valid, obj_error, obj_data}, 10'h208);
		@(posedge mclk) {wr_en, wr_data} <= 9'h1ff;
		qsim_host_inst.ask(8'h00, 16'h6003, 8'h05);
		chk("rd_wr", rd_data, 8'h08);
		chk("obj_bad", {obj_valid, obj_error, obj_data}, 10'h300);
		$display("inputs test done");
		for (i = 0; i < 4; i = i + 1)
		begin
			@(posedge mclk) {bus_power_ok, bus_comm_ok, module_error} <= tbl[i * 5 + 2 +: 3];
			repeat (2) @(posedge mclk);
			#1 chk("leds", {run_led, module_fault_led}, tbl[i * 5 +: 2]);
			chk("chan_pwr", channel_led, 4'h8);
		end
		$display("leds test done");
		@(posedge mclk) {config_error, module_error} <= 2'h3;
		repeat (2) @(posedge mclk);
		#1 chk("cfg", {run_led, module_fault_led}, 2'h2);
		@(posedge mclk) config_error <= 1'h0;
		repeat (2) @(posedge mclk);
		#1 chk("cfg_off", {run_led, module_fault_led}, 2'h3);
		$display("config test done");
		results;
	end
endmodule // quad_sinking_input_module_test
